// ### common/see_cfg.svh
/*
 * constants for the serial eeprom command and protect block.
 * assumes a 10 MHz reference clock and a 64K x 8 array.
 */
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// opcode values with the don't-care bit cleared
`define SEE_OP_MASK 8'hF7
`define SEE_OP_SET_LATCH 8'h06
`define SEE_OP_CLEAR_LATCH 8'h04
`define SEE_OP_READ_STATUS 8'h05
`define SEE_OP_WRITE_STATUS 8'h01
`define SEE_OP_READ 8'h03
`define SEE_OP_WRITE 8'h02

// status bit positions and the busy read-back value
`define SEE_ST_BUSY 0
`define SEE_ST_WEN 1
`define SEE_ST_BP_LO 2
`define SEE_ST_BP_SP 4
`define SEE_ST_HW_PROTECT_ENABLE 7
`define SEE_ST_ALL_BUSY 8'hFF

// block protect levels
`define SEE_BP_NONE 2'h0
`define SEE_BP_QUARTER 2'h1
`define SEE_BP_HALF 2'h2
`define SEE_BP_ALL 2'h3

// geometry and timing
`define SEE_ADDR_BITS 16
`define SEE_PAGE_BYTES 128
`define SEE_WRITE_TIME_NS 5000000
`define SEE_REF_PERIOD_NS 100

`endif

// ### common/see_pkg.sv
/*
 * types and opcode decoding shared by the eeprom block.
 * assumes see_cfg.svh is on the include path.
 */
`include "see_cfg.svh"

package see_pkg;

    typedef enum logic [2:0] {
        cmd_none = 3'b000,
        set_latch_cmd = 3'b001,
        clear_latch_cmd = 3'b010,
        read_status_cmd = 3'b011,
        write_status_cmd = 3'b100,
        cmd_read = 3'b101,
        cmd_write = 3'b110
    } see_cmd_e;

    typedef enum logic [2:0] {
        ph_opcode = 3'b000,
        ph_addr = 3'b001,
        ph_status = 3'b010,
        ph_rdata = 3'b011,
        ph_wdata = 3'b100,
        ph_sdata = 3'b101,
        ph_ignore = 3'b110
    } see_phase_e;

    typedef struct packed {
        logic hw_protect_enable;
        logic [1:0] spare;
        logic block_protect_spare;
        logic block_protect_high;
        logic block_protect_low;
        logic wen;
        logic busy;
    } see_status_s;

    // bit 3 of the opcode is don't care
    function automatic see_cmd_e see_decode(input logic [7:0] op);
        logic [7:0] m;
        m = op & `SEE_OP_MASK;
        case (m)
            `SEE_OP_SET_LATCH: return set_latch_cmd;
            `SEE_OP_CLEAR_LATCH: return clear_latch_cmd;
            `SEE_OP_READ_STATUS: return read_status_cmd;
            `SEE_OP_WRITE_STATUS: return write_status_cmd;
            `SEE_OP_READ: return cmd_read;
            `SEE_OP_WRITE: return cmd_write;
            default: return cmd_none;
        endcase
    endfunction

endpackage

// ### src/see_core.sv
/*
 * serial eeprom command decode, status register and write protection.
 * assumes sck_i runs only while cs_n_i is low and that the master keeps
 * the frame end on a byte boundary; array storage lives in this module.
 */
// What this block does
// - hardware protection on only when protect pin low and enable bit set
// - hold freezes clock, input and output; sequence resumes after
// - hold tied high means hold never acts
// - status read-only while hardware protection on or latch clear
// - bit 0 shows busy; while busy only read-status is taken
// - bit 1 is the latch, cleared at power-up, set by set-latch
// - bits 2 to 4 are block protect bits, reset value zero
// - bits 5 and 6 keep nothing and read zero when idle
// - enable bit cannot fall from 1 to 0 while protect pin low
// - every status bit reads one during an internal write
// - low protect bits pick none, top quarter, top half, or all
// - writes inside the protected block are dropped
// - array writes need the latch; hardware protection ignores array
// - decode set-latch, clear-latch and read-status opcodes
// - decode write-status, array read and array write opcodes
// - input sampled on rising clock, most significant bit first
// - output bits change on the falling clock edge
// - latch cleared by clear-latch, status write and array write
// - read-status repeats the status byte while clocking goes on
// - status write needs latch, no hardware protection; applied at end
// - array read takes 16-bit address, streams, wraps at the top
// - array write fills one page, wraps inside, keeps last bytes
// - works in clock modes 0 and 3
// - internal write cycle ends within 5 ms
// - output released while deselected
`timescale 1ns/1ns
`default_nettype none
`include "see_cfg.svh"

module see_core
    import see_pkg::*;
#(
    parameter int WRITE_CYCLES = `SEE_WRITE_TIME_NS / `SEE_REF_PERIOD_NS,
    parameter int PAGE_BYTES = `SEE_PAGE_BYTES
) (
    // reference clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // serial link pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    output logic so_o,
    output logic so_oe_o,
    // write protect pin
    input wire logic wp_n_i,
    // observation
    output logic [7:0] status_o,
    output logic busy_o
);
    localparam int AW = `SEE_ADDR_BITS;
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam logic [TW-1:0] LAST_TICK = TW'(WRITE_CYCLES - 1);
    localparam logic [TW-1:0] PAGE_TICKS = TW'(PAGE_BYTES);

    // protected region test on an array address
    function automatic logic see_prot(input logic [1:0] bp,
                                      input logic [AW-1:0] a);
        case (bp)
            `SEE_BP_QUARTER: return a[AW-1] & a[AW-2];
            `SEE_BP_HALF: return a[AW-1];
            `SEE_BP_ALL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // array, written on ref clock, read on link clock only when idle
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] page [0:PAGE_BYTES-1];

    // link domain state
    logic frame_rst_n;
    logic [2:0] bit_reg;
    logic abyte_reg;
    see_phase_e phase_reg, phase_next;
    logic [7:0] sh_reg, op_reg, sr_data_reg, tx_reg;
    logic [7:0] st_m_reg, st_s_reg;
    logic [AW-1:0] addr_reg, addr_next;
    logic [PAGE_BYTES-1:0] loaded_reg;
    logic sr_got_reg, tog_reg, so_reg, oe_reg;

    // ref domain state
    logic cs_m_reg, cs_s_reg, cs_d_reg;
    logic tog_m_reg, tog_s_reg, seen_tog_reg;
    logic wp_m_reg, wp_s_reg;
    logic wen_reg, wen_next, busy_reg, busy_next, kind_reg;
    logic hw_protect_enable_reg, hw_protect_enable_next;
    logic [2:0] bp_reg, bp_next;
    logic [TW-1:0] timer_reg;
    see_status_s st_live;

    // link decoding
    wire logic [7:0] byte_in = {sh_reg[6:0], si_i};
    wire logic byte_end = (bit_reg == 3'h7);
    wire see_cmd_e cmd_in = see_decode(byte_in);
    wire see_cmd_e cmd_op = see_decode(op_reg);
    wire logic busy_s = st_s_reg[`SEE_ST_BUSY];
    wire logic [AW-1:0] full_addr = {addr_reg[AW-9:0], byte_in};
    wire logic [AW-1:0] rd_ptr = (phase_reg == ph_addr) ? full_addr
                                                        : addr_reg;
    wire logic talk = (phase_next == ph_status) | (phase_next == ph_rdata);
    wire logic [7:0] tx_next = (phase_next == ph_status) ? st_s_reg
                                                         : mem[rd_ptr];

    // a high chip select clears the per-frame sequencer
    assign frame_rst_n = rstn_i & ~cs_n_i;

    // phase sequencing at each byte boundary
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            ph_opcode: begin
                if (busy_s && cmd_in != read_status_cmd) begin
                    phase_next = ph_ignore;
                end else begin
                    unique case (cmd_in)
                        read_status_cmd: phase_next = ph_status;
                        cmd_read: phase_next = ph_addr;
                        cmd_write: phase_next = ph_addr;
                        write_status_cmd: phase_next = ph_sdata;
                        default: phase_next = ph_ignore;
                    endcase
                end
            end
            ph_addr: begin
                if (abyte_reg) begin
                    phase_next = (cmd_op == cmd_read) ? ph_rdata : ph_wdata;
                end
            end
            ph_sdata: phase_next = ph_ignore;
            ph_status, ph_rdata, ph_wdata, ph_ignore: phase_next = phase_reg;
        endcase
    end

    // address stepping: whole array for reads, one page for writes
    always_comb begin
        unique case (phase_reg)
            ph_addr: addr_next = (abyte_reg && cmd_op == cmd_read)
                                 ? full_addr + 16'h0001 : full_addr;
            ph_rdata: addr_next = addr_reg + 16'h0001;
            ph_wdata: addr_next = {addr_reg[AW-1:PW],
                                   addr_reg[PW-1:0] + PW'(1)};
            default: addr_next = addr_reg;
        endcase
    end

    // sequencer, frozen while hold is low
    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_reg <= 3'h0;
            phase_reg <= ph_opcode;
            abyte_reg <= 1'b0;
        end else if (hold_n_i) begin
            bit_reg <= bit_reg + 3'h1;
            if (byte_end) begin
                phase_reg <= phase_next;
                abyte_reg <= (phase_reg == ph_addr);
            end
        end
    end

    // captured frame contents, kept after the frame for the ref side
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_reg <= 8'h00;
            op_reg <= 8'h00;
            tog_reg <= 1'b0;
            addr_reg <= 16'h0000;
            tx_reg <= 8'h00;
            sr_data_reg <= 8'h00;
            sr_got_reg <= 1'b0;
            loaded_reg <= '0;
        end else if (hold_n_i && !cs_n_i) begin
            sh_reg <= byte_in;
            if (byte_end) begin
                addr_reg <= addr_next;
                if (talk) begin
                    tx_reg <= tx_next;
                end
                if (phase_reg == ph_opcode) begin
                    op_reg <= byte_in;
                    tog_reg <= ~tog_reg;
                end
                // a status poll during a write cycle must keep the page
                if (phase_reg == ph_opcode && !busy_s) begin
                    loaded_reg <= '0;
                    sr_got_reg <= 1'b0;
                end
                if (phase_reg == ph_wdata) begin
                    loaded_reg[addr_reg[PW-1:0]] <= 1'b1;
                end
                if (phase_reg == ph_sdata) begin
                    sr_data_reg <= byte_in;
                    sr_got_reg <= 1'b1;
                end
            end
        end
    end

    // page buffer: a later byte at the same slot overwrites the earlier
    always_ff @(posedge sck_i) begin
        if (hold_n_i && !cs_n_i && byte_end && phase_reg == ph_wdata) begin
            page[addr_reg[PW-1:0]] <= byte_in;
        end
    end

    // status into the link domain, first stage read by second only
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_m_reg <= 8'h00;
            st_s_reg <= 8'h00;
        end else begin
            st_m_reg <= status_o;
            st_s_reg <= st_m_reg;
        end
    end

    // output shifts on the falling edge, msb first
    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (hold_n_i) begin
            so_reg <= tx_reg[3'h7 - bit_reg];
            oe_reg <= (phase_reg == ph_status) | (phase_reg == ph_rdata);
        end
    end

    // released when deselected or held
    assign so_o = so_reg;
    assign so_oe_o = oe_reg & hold_n_i & ~cs_n_i;

    // ref domain decoding
    wire logic cs_rise = cs_s_reg & ~cs_d_reg;
    wire logic commit = cs_rise & (tog_s_reg != seen_tog_reg);
    wire logic hw_prot = hw_protect_enable_reg & ~wp_s_reg;
    wire logic accept = commit & ~busy_reg;
    wire logic do_set = accept & (cmd_op == set_latch_cmd);
    wire logic do_clr = accept & (cmd_op == clear_latch_cmd);
    wire logic do_wsr = accept & (cmd_op == write_status_cmd) &
                        sr_got_reg & wen_reg & ~hw_prot;
    wire logic do_war = accept & (cmd_op == cmd_write) &
                        wen_reg & (|loaded_reg);
    wire logic done = busy_reg & (timer_reg == LAST_TICK);
    wire logic [PW-1:0] idx = timer_reg[PW-1:0];
    wire logic [AW-1:0] mem_addr = {addr_reg[AW-1:PW], idx};
    wire logic mem_we = busy_reg & ~kind_reg & (timer_reg < PAGE_TICKS) &
                        loaded_reg[idx] & ~see_prot(bp_reg[1:0], mem_addr);

    // latch, busy and protect bits
    assign wen_next = do_set ? 1'b1 : (do_clr | done) ? 1'b0
                                                      : wen_reg;
    assign busy_next = (do_wsr | do_war) ? 1'b1 : done ? 1'b0 : busy_reg;
    assign bp_next = (done & kind_reg)
                     ? sr_data_reg[`SEE_ST_BP_SP:`SEE_ST_BP_LO]
                     : bp_reg;
    assign hw_protect_enable_next = (done & kind_reg)
                       ? (sr_data_reg[`SEE_ST_HW_PROTECT_ENABLE] | hw_prot)
                       : hw_protect_enable_reg;

    // status view: bits 5 and 6 keep nothing
    always_comb begin
        st_live.hw_protect_enable = hw_protect_enable_next;
        st_live.spare = 2'b00;
        st_live.block_protect_spare = bp_next[2];
        st_live.block_protect_high = bp_next[1];
        st_live.block_protect_low = bp_next[0];
        st_live.wen = wen_next;
        st_live.busy = busy_next;
    end

    // pin synchronisers and control registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            tog_m_reg <= 1'b0;
            tog_s_reg <= 1'b0;
            seen_tog_reg <= 1'b0;
            wp_m_reg <= 1'b1;
            wp_s_reg <= 1'b1;
            wen_reg <= 1'b0;
            busy_reg <= 1'b0;
            kind_reg <= 1'b0;
            bp_reg <= 3'h0;
            hw_protect_enable_reg <= 1'b0;
            timer_reg <= '0;
            status_o <= 8'h00;
        end else begin
            cs_m_reg <= cs_n_i;
            cs_s_reg <= cs_m_reg;
            cs_d_reg <= cs_s_reg;
            tog_m_reg <= tog_reg;
            tog_s_reg <= tog_m_reg;
            if (cs_rise) begin
                seen_tog_reg <= tog_s_reg;
            end
            wp_m_reg <= wp_n_i;
            wp_s_reg <= wp_m_reg;
            wen_reg <= wen_next;
            busy_reg <= busy_next;
            if (do_wsr | do_war) begin
                kind_reg <= do_wsr;
            end
            bp_reg <= bp_next;
            hw_protect_enable_reg <= hw_protect_enable_next;
            timer_reg <= busy_reg & ~done ? timer_reg + TW'(1) : '0;
            status_o <= busy_next ? `SEE_ST_ALL_BUSY : st_live;
        end
    end

    // page copy into the array during the write cycle
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[mem_addr] <= page[idx];
        end
    end

    assign busy_o = busy_reg;

    // checks
    property p_wsr_refused;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && cmd_op == write_status_cmd && hw_prot |=> !busy_reg;
    endproperty
    a_wsr_refused: assert property (p_wsr_refused)
        else $error("status write taken under hardware protection");

    property p_latch_set;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        commit && !busy_reg && cmd_op == set_latch_cmd |=> wen_reg;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("set-latch did not set the latch");

    property p_latch_end;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(busy_reg) |-> !wen_reg && status_o[`SEE_ST_WEN] == 1'b0;
    endproperty
    a_latch_end: assert property (p_latch_end)
        else $error("latch still set after write cycle");

    property p_busy_ones;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        busy_reg |-> status_o == `SEE_ST_ALL_BUSY;
    endproperty
    a_busy_ones: assert property (p_busy_ones)
        else $error("status not all ones while busy");

    property p_busy_ignores;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        commit && busy_reg && !done && wen_reg |=> wen_reg;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores)
        else $error("command acted on while busy");

    property p_hw_protect_enable_kept;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        hw_protect_enable_reg && !wp_s_reg |=> hw_protect_enable_reg;
    endproperty
    a_hw_protect_enable_kept: assert property (p_hw_protect_enable_kept)
        else $error("enable bit fell while protect pin low");

    property p_bp_held;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        busy_reg && !done |=> $stable(bp_reg) && $stable(hw_protect_enable_reg);
    endproperty
    a_bp_held: assert property (p_bp_held)
        else $error("protect bits changed before write cycle end");

    property p_guard;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        mem_we |-> busy_reg && !(bp_reg[1] && bp_reg[0]) &&
            !(bp_reg[1] && mem_addr[AW-1]) &&
            !(bp_reg[0] && mem_addr[AW-1] && mem_addr[AW-2]);
    endproperty
    a_guard: assert property (p_guard)
        else $error("write into protected block");

    property p_cycle_len;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(busy_reg) |-> busy_reg[*8];
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("write cycle ended too early");

    property p_ignore_quiet;
        @(posedge sck_i) disable iff (!frame_rst_n)
        phase_reg == ph_ignore |=> phase_reg == ph_ignore && !oe_reg;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet)
        else $error("ignored frame became active");

    c_array_write: cover property (@(posedge ref_clk_i) do_war);
    c_status_write: cover property (@(posedge ref_clk_i) do_wsr);
    c_busy_poll: cover property (@(posedge sck_i)
        phase_reg == ph_status && busy_s);
    c_read_stream: cover property (@(posedge sck_i)
        phase_reg == ph_rdata && byte_end);

endmodule

`default_nettype wire

// ### verif/see_master.sv
/*
 * behavioural spi master driving the eeprom link pins in mode 0 or 3.
 * assumes the bench calls start, xfer and stop in that order.
 */
`timescale 1ns/1ns
`default_nettype none

module see_master
    import see_pkg::*;
(
    // data returned by the device
    input wire logic so_i,
    // pins driven by the master
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o
);

    // clock level between frames: low for mode 0, high for mode 3
    bit idle_hi;

    // clock parked low between frames, hold kept released
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end

    // select the device a little ahead of the first edge
    task automatic start();
        cs_n_o = 1'b0;
        #6;
    endtask

    // deselect after the last clock edge (falling in mode 0, rising in mode 3), then a gap for frame end
    task automatic stop();
        #3;
        cs_n_o = 1'b1;
        #600;
    endtask

    // pick the clock mode; only called while deselected
    task automatic set_mode(input bit hi);
        idle_hi = hi;
        sck_o = hi;
        #6;
    endtask

    // one byte each way, msb first; so is taken at the rising edge
    task automatic xfer(input logic [7:0] tx, input bit hold,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (idle_hi) begin
                #6 sck_o = 1'b0;
            end
            si_o = tx[i];
            if (hold && i == 3) begin
                // hold moves clear of the falling edge, never with it
                #3 hold_n_o = 1'b0;
                // clocks and data while held must leave no trace
                repeat (3) begin
                    #6 sck_o = 1'b1;
                    si_o = ~si_o;
                    #6 sck_o = 1'b0;
                end
                #100 hold_n_o = 1'b1;
                si_o = tx[i];
            end
            #6 sck_o = 1'b1;
            rx[i] = so_i;
            if (!idle_hi) begin
                #6 sck_o = 1'b0;
            end
        end
    endtask

endmodule

`default_nettype wire

// ### verif/tb_spi_eeprom_command_protect.sv
/*
 * self-checking bench for see_core with a reference model in an associative array.
 * assumes see_master sits on the link; write cycle shortened to 200.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_spi_eeprom_command_protect
    import see_pkg::*;
;
    localparam int WC = 200;
    logic ref_clk, rstn, wp_n, sck, cs_n, si, hold_n, so, so_oe, busy, junk;
    logic [7:0] status;
    logic [7:0] mem [int];
    bit mwen, mwpen;
    logic [2:0] mbp;
    int errors, checks_done;
    // released output shows a toggling level, never a held one
    wire logic so_w = so_oe ? so : junk;

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial junk = 1'b0;
    always @(posedge ref_clk) junk <= ~junk;

    see_core #(.WRITE_CYCLES(WC)) u_dut (.ref_clk_i(ref_clk),
        .rstn_i(rstn), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n),
        .status_o(status), .busy_o(busy));
    see_master u_mst (.so_i(so_w), .sck_o(sck), .cs_n_o(cs_n),
        .si_o(si), .hold_n_o(hold_n));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_st();
        return {mwpen, 2'b00, mbp, mwen, 1'b0};
    endfunction

    // protected region from the two low block bits
    function automatic bit prot(input logic [15:0] a);
        return (mbp[1] && (mbp[0] || a[15])) || (mbp[0] && a[15:14] == 2'h3);
    endfunction

    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        u_mst.start();
        u_mst.xfer(op, 1'b0, r);
        u_mst.stop();
    endtask

    task automatic rd_st(input logic [7:0] exp, input bit hold);
        logic [7:0] r;
        u_mst.start();
        u_mst.xfer(8'h05, 1'b0, r);
        repeat (2) begin
            u_mst.xfer(8'($urandom), hold, r);
            check(r, exp);
        end
        u_mst.stop();
    endtask

    // let the command land; a write cycle is probed while it runs
    task automatic fin(input bit acc);
        int n;
        repeat (8) @(negedge ref_clk);
        check(busy, acc);
        if (acc) begin
            check(status, 8'hFF);
            rd_st(8'hFF, 1'b0);
            cmd(8'h06);
            n = 0;
            while (busy !== 1'b0 && n < WC + 50) begin
                @(negedge ref_clk);
                n++;
            end
            check(busy, 1'b0);
            repeat (8) @(negedge ref_clk);
        end
        check(status, exp_st());
        check(so_oe, 1'b0);
    endtask

    task automatic latch();
        cmd(8'h06 | {4'h0, 1'($urandom), 3'h0});
        mwen = 1'b1;
        fin(1'b0);
    endtask

    task automatic wr_st(input logic [7:0] v);
        logic [7:0] r;
        bit acc;
        acc = mwen && !(mwpen && !wp_n);
        u_mst.start();
        u_mst.xfer(8'h01, 1'b0, r);
        u_mst.xfer(v, 1'b0, r);
        u_mst.stop();
        if (acc) begin
            mbp = v[4:2];
            mwpen = v[7];
            mwen = 1'b0;
        end
        fin(acc);
    endtask

    task automatic wr_arr(input logic [15:0] a, input int n);
        logic [7:0] r;
        logic [7:0] d;
        logic [15:0] pa;
        bit acc;
        acc = mwen;
        u_mst.start();
        u_mst.xfer(8'h02, 1'b0, r);
        u_mst.xfer(a[15:8], 1'b0, r);
        u_mst.xfer(a[7:0], 1'b0, r);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            pa = {a[15:7], 7'(a[6:0] + i)};
            u_mst.xfer(d, 1'b0, r);
            if (acc && !prot(pa))
                mem[pa] = d;
        end
        u_mst.stop();
        if (acc)
            mwen = 1'b0;
        fin(acc);
    endtask

    task automatic rd_arr(input logic [15:0] a, input int n);
        logic [7:0] r;
        logic [15:0] ea;
        u_mst.start();
        u_mst.xfer(8'h0B, 1'b0, r);
        u_mst.xfer(a[15:8], 1'b0, r);
        u_mst.xfer(a[7:0], 1'b0, r);
        for (int i = 0; i < n; i++) begin
            ea = a + 16'(i);
            u_mst.xfer(8'($urandom), i == 1, r);
            if (mem.exists(ea))
                check(r, mem[ea]);
        end
        u_mst.stop();
        fin(1'b0);
    endtask

    task automatic complete_run();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // output must let go while held
    always @(negedge hold_n) begin
        #50;
        check(so_oe, 1'b0);
    end

    initial begin
        #5000000;
        errors++;
        complete_run();
    end

    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        mbp = 3'h0;
        void'($urandom(32'hBCF9));
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check(status, 8'h00);
        rd_st(8'h00, 1'b1);
        for (int k = 0; k < 2; k++) begin
            cmd(8'h06 | 8'(k << 3));
            mwen = 1'b1;
            fin(1'b0);
            cmd(8'h80 | 8'($urandom));
            fin(1'b0);
            cmd(8'h04 | 8'(k << 3));
            mwen = 1'b0;
            fin(1'b0);
        end
        wr_arr(16'h0000, 1);
        latch();
        wr_arr(16'h107E, 130);
        latch();
        wr_arr(16'hFFFF, 1);
        latch();
        wr_arr(16'h0000, 1);
        rd_arr(16'h1000, 128);
        rd_arr(16'hFFFF, 2);
        wr_st(8'h8C);
        latch();
        wr_st({1'b1, 2'($urandom), 3'b101, 2'($urandom)});
        @(negedge ref_clk);
        wp_n = 1'b0;
        latch();
        wr_st(8'h00);
        wr_arr(16'h0000, 1);
        latch();
        wr_arr(16'hFF00, 3);
        rd_arr(16'hFFFF, 2);
        @(negedge ref_clk);
        wp_n = 1'b1;
        // every protect level against one byte in each quarter
        for (int b = 0; b < 4; b++) begin
            latch();
            wr_st(8'(b << 2));
            for (int j = 0; j < 4; j++) begin
                latch();
                wr_arr(16'(j << 14), 1);
                rd_arr(16'(j << 14), 1);
            end
        end
        // mode 3: clock parked high between frames
        u_mst.set_mode(1'b1);
        rd_st(exp_st(), 1'b1);
        rd_arr(16'h1000, 2);
        u_mst.set_mode(1'b0);
        complete_run();
    end

endmodule

`default_nettype wire
